// ---- src/stt_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
module stt_seq #(
   parameter int          PHASES   = 1,
   parameter logic [10:0] DLY_MAN  = 11'h000,
   parameter logic [10:0] RISE_MAN = 11'h00C,
   parameter logic [10:0] TMO_MAN  = 11'h000
)
(
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // Word command port
   input  wire logic                 cmd_valid,
   input  wire logic                 cmd_write,
   input  wire logic [7:0]           cmd_code,
   input  wire logic [15:0]          cmd_wdata,
   output logic                      cmd_ack,
   output logic                      cmd_err,
   output logic [15:0]               cmd_rdata,
   // Restore and fault clearing
   input  wire logic                 restore,
   input  wire logic                 clear_faults,
   // Start condition pin
   input  wire logic                 start_pin,
   // Telemetry, 1/16 V units
   input  wire logic [PHASES*16-1:0] power_input_rail,
   input  wire logic [15:0]          vout_sample,
   input  wire logic                 vout_sample_valid,
   input  wire logic [15:0]          vout_command,
   // Power stage control
   output logic                      output_enable,
   output logic                      ramp_active,
   output logic [15:0]               ref_level,
   output logic                      uv_compare_enable,
   // Status
   output logic [PHASES-1:0]         input_uv_warning_flag,
   output logic [7:0]                status_byte,
   output logic [15:0]               status_word,
   output logic [7:0]                status_input,
   output logic [7:0]                status_vout,
   output logic [7:0]                status_cml,
   output logic                      notify_host
);
   import stt_pkg::*;

   // ------------------------------------------------------------
   // Start pin synchroniser
   // ------------------------------------------------------------
   logic s1_q, s2_q, s3_q, start_lvl_q;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         start_lvl_q <= 1'b0;
      end
      else
      begin
         s1_q <= start_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            start_lvl_q <= s3_q;
      end
   end
   wire logic start_rise;
   wire logic start_fall;
   assign start_rise = (s2_q == s3_q) & s3_q & ~start_lvl_q;
   assign start_fall = (s2_q == s3_q) & ~s3_q & start_lvl_q;

   // ------------------------------------------------------------
   // Register write decode
   // ------------------------------------------------------------
   logic [15:0] uv_word_q, dly_word_q, rise_word_q, tmo_word_q;
   logic        uv_lock_q;

   wire logic        wr;
   wire logic        hit_uv, hit_dly, hit_rise, hit_tmo, hit_any;
   wire logic [19:0] wr_v, wr_t;
   wire logic        uv_ok, dly_ok, rise_ok, tmo_ok, wr_ok;
   assign wr       = cmd_valid & cmd_write;
   assign hit_uv   = (cmd_code == CMD_UV_WARN);
   assign hit_dly  = (cmd_code == CMD_TON_DLY);
   assign hit_rise = (cmd_code == CMD_RAMP_TIME);
   assign hit_tmo  = (cmd_code == CMD_TMO_LIMIT);
   assign hit_any  = hit_uv | hit_dly | hit_rise | hit_tmo;
   assign wr_v     = stt_lin_fix(cmd_wdata, V_FRAC);
   assign wr_t     = stt_lin_fix(cmd_wdata, T_FRAC);
   assign uv_ok    = (wr_v >= UV_MIN) && (wr_v <= UV_MAX)
                     && !(uv_lock_q && wr_v < UV_MIN);
   assign dly_ok   = (wr_t <= DLY_MAX) && !wr_t[0];
   assign rise_ok  = (wr_t <= RISE_MAX);
   assign tmo_ok   = (wr_t <= TMO_MAX) && !wr_t[0];
   assign wr_ok    = (hit_uv & uv_ok) | (hit_dly & dly_ok)
                     | (hit_rise & rise_ok) | (hit_tmo & tmo_ok);

   wire logic bad_data;
   wire logic bad_cmd;
   assign bad_data = wr & hit_any & ~wr_ok;
   assign bad_cmd  = cmd_valid & ~hit_any;

   // Restore rounds stored delay to whole half milliseconds
   wire logic [19:0] dly_cur_q4;
   wire logic [8:0]  dly_half;
   assign dly_cur_q4 = stt_lin_fix(dly_word_q, T_FRAC);
   assign dly_half   = 9'((dly_cur_q4 + 20'h0_0001) >> 1);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         uv_word_q   <= {UV_EXP_RST, UV_MAN_RST};
         dly_word_q  <= {DLY_EXP_RST, DLY_MAN};
         rise_word_q <= {RISE_EXP_RST, RISE_MAN};
         tmo_word_q  <= {TMO_EXP_RST, TMO_MAN};
         uv_lock_q   <= 1'b0;
      end
      else
      begin
         if (wr && hit_uv && uv_ok)
         begin
            uv_word_q <= cmd_wdata;
            if (wr_v > UV_MIN)
               uv_lock_q <= 1'b1;
         end
         if (restore)
            dly_word_q <= {DLY_EXP_RST, 2'b00, dly_half};
         else if (wr && hit_dly && dly_ok)
            dly_word_q <= cmd_wdata;
         if (wr && hit_rise && rise_ok)
            rise_word_q <= cmd_wdata;
         if (wr && hit_tmo && tmo_ok)
            tmo_word_q <= cmd_wdata;
      end
   end

   // ------------------------------------------------------------
   // Word read and answer
   // ------------------------------------------------------------
   wire logic [15:0] rd_mux;
   assign rd_mux = hit_uv   ? uv_word_q   :
                   hit_dly  ? dly_word_q  :
                   hit_rise ? rise_word_q :
                   hit_tmo  ? tmo_word_q  : 16'h0000;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cmd_ack   <= 1'b0;
         cmd_err   <= 1'b0;
         cmd_rdata <= 16'h0000;
      end
      else
      begin
         cmd_ack   <= cmd_valid;
         cmd_err   <= bad_data | bad_cmd;
         if (cmd_valid && !cmd_write)
            cmd_rdata <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Timer settings in quarter milliseconds
   // ------------------------------------------------------------
   wire logic [9:0] dly_q4, rise_q4, rise_eff, tmo_q4;
   assign dly_q4   = dly_cur_q4[9:0];
   assign rise_q4  = 10'(stt_lin_fix(rise_word_q, T_FRAC));
   assign rise_eff = (rise_q4 < RISE_FLOOR) ? RISE_FLOOR : rise_q4;
   assign tmo_q4   = 10'(stt_lin_fix(tmo_word_q, T_FRAC));

   // ------------------------------------------------------------
   // Time base and phase monitors
   // ------------------------------------------------------------
   stt_state_e st_q, st_d;
   wire logic  tick;
   wire logic  tick_restart;
   // Realign the base at start and at delay and ramp entry
   assign tick_restart = start_rise
                         | ((st_d != st_q)
                            && (st_d == ST_DELAY || st_d == ST_RAMP));
   stt_tick u_tick (
      .mclk    (mclk),
      .rst     (rst),
      .restart (tick_restart),
      .tick    (tick)
   );

   stt_mon_if #(.PHASES(PHASES)) mon_if ();
   assign mon_if.threshold = 16'(stt_lin_fix(uv_word_q, V_FRAC));
   assign mon_if.rail      = power_input_rail;
   assign input_uv_warning_flag = mon_if.uvw;

   stt_uv_mon #(.PHASES(PHASES)) u_uv (
      .mclk (mclk),
      .rst  (rst),
      .mon  (mon_if.mon)
   );

   // ------------------------------------------------------------
   // Start-up sequence
   // ------------------------------------------------------------
   localparam logic [9:0] INIT_LAST = 10'(INIT_CYC - 1);
   logic [9:0]  cnt_q, init_q, tmo_cnt_q;
   logic        init_done_q, tmo_run_q;
   logic [11:0] pend_q, frac_q;
   logic [15:0] last_vout_q;

   wire logic dly_done, ramp_done, init_done_now;
   assign init_done_now = (st_q == ST_INIT) && (init_q == INIT_LAST);
   assign dly_done  = (st_q == ST_DELAY) && (cnt_q == dly_q4);
   assign ramp_done = (st_q == ST_RAMP) && (cnt_q == rise_eff);

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:  if (start_rise)
                      st_d = init_done_q ? ST_DELAY : ST_INIT;
         ST_INIT:  if (init_done_now)
                      st_d = ST_DELAY;
         ST_DELAY: if (dly_done)
                      st_d = ST_RAMP;
         ST_RAMP:  if (ramp_done)
                      st_d = ST_ON;
         ST_ON:    st_d = ST_ON;
         default:  st_d = ST_IDLE;
      endcase
      if (start_fall)
         st_d = ST_IDLE;
      else if (start_rise && st_q != ST_IDLE)
         st_d = init_done_q ? ST_DELAY : ST_INIT;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_q        <= ST_IDLE;
         init_q      <= 10'h000;
         init_done_q <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         init_q <= (st_q == ST_INIT) ? init_q + 10'h001 : 10'h000;
         if (init_done_now)
            init_done_q <= 1'b1;
      end
   end

   // Phase counter, zeroed on every state change
   always_ff @(posedge mclk)
   begin
      if (rst || st_d != st_q || start_rise)
         cnt_q <= 10'h000;
      else if (tick)
         cnt_q <= cnt_q + 10'h001;
   end

   // Reference ramp: 1024 parts spread over rise_eff ticks
   wire logic        pend_sub;
   wire logic [11:0] pend_add;
   assign pend_sub = (st_q == ST_RAMP) && (pend_q >= {2'b00, rise_eff});
   assign pend_add = (tick && st_q == ST_RAMP) ? RAMP_FULL : 12'h000;

   always_ff @(posedge mclk)
   begin
      if (rst || st_q == ST_IDLE || st_q == ST_DELAY || st_q == ST_INIT)
      begin
         pend_q <= 12'h000;
         frac_q <= 12'h000;
      end
      else if (st_q == ST_ON)
         frac_q <= RAMP_FULL;
      else
      begin
         pend_q <= pend_q + pend_add - (pend_sub ? {2'b00, rise_eff} : 12'h000);
         if (pend_sub && frac_q < RAMP_FULL)
            frac_q <= frac_q + 12'h001;
      end
   end

   wire logic [27:0] ref_prod;
   assign ref_prod = vout_command * frac_q;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ref_level         <= 16'h0000;
         output_enable     <= 1'b0;
         ramp_active       <= 1'b0;
         uv_compare_enable <= 1'b0;
      end
      else
      begin
         ref_level         <= ref_prod[25:10];
         output_enable     <= (st_d == ST_RAMP) || (st_d == ST_ON);
         ramp_active       <= (st_d == ST_RAMP);
         uv_compare_enable <= (st_d == ST_ON);
      end
   end

   // ------------------------------------------------------------
   // Start-up timeout
   // ------------------------------------------------------------
   wire logic        tmo_expire, tmo_fault;
   wire logic [18:0] vout_x8, target_x7;
   assign tmo_expire = tmo_run_q && (tmo_cnt_q == tmo_q4)
                       && (tmo_q4 != 10'h000);
   assign vout_x8    = {last_vout_q, 3'b000};
   assign target_x7  = 19'(vout_command) * 19'd7;
   assign tmo_fault  = tmo_expire && (vout_x8 < target_x7);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tmo_run_q   <= 1'b0;
         tmo_cnt_q   <= 10'h000;
         last_vout_q <= 16'h0000;
      end
      else
      begin
         if (vout_sample_valid)
            last_vout_q <= vout_sample;
         if (dly_done || start_rise || start_fall || tmo_expire)
         begin
            tmo_run_q <= dly_done && (tmo_q4 != 10'h000);
            tmo_cnt_q <= 10'h000;
         end
         else if (tmo_run_q && tick)
            tmo_cnt_q <= tmo_cnt_q + 10'h001;
      end
   end

   // ------------------------------------------------------------
   // Sticky status, set wins over clear
   // ------------------------------------------------------------
   wire logic uvw_any;
   assign uvw_any = |mon_if.uvw;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         status_byte  <= 8'h00;
         status_word  <= 16'h0000;
         status_input <= 8'h00;
         status_vout  <= 8'h00;
         status_cml   <= 8'h00;
      end
      else
      begin
         if (clear_faults)
         begin
            status_byte  <= 8'h00;
            status_word  <= 16'h0000;
            status_input <= 8'h00;
            status_vout  <= 8'h00;
            status_cml   <= 8'h00;
         end
         if (uvw_any)
         begin
            status_byte[SB_NONE_ABOVE] <= 1'b1;
            status_word[SB_NONE_ABOVE] <= 1'b1;
            status_word[SW_INPUT]      <= 1'b1;
            status_input[SI_UV_WARN]   <= 1'b1;
         end
         if (tmo_fault)
         begin
            status_byte[SB_NONE_ABOVE] <= 1'b1;
            status_word[SB_NONE_ABOVE] <= 1'b1;
            status_word[SW_VOUT]       <= 1'b1;
            status_vout[SV_STARTUP_TMO] <= 1'b1;
         end
         if (bad_data || bad_cmd)
         begin
            status_byte[SB_CML] <= 1'b1;
            status_word[SB_CML] <= 1'b1;
         end
         if (bad_data)
            status_cml[SC_BAD_DATA] <= 1'b1;
         if (bad_cmd)
            status_cml[SC_BAD_CMD] <= 1'b1;
      end
   end

   assign notify_host = |status_byte;

endmodule // stt_seq
`default_nettype wire

// ---- src/stt_pkg.sv ----
package stt_pkg;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_UV_WARN = 8'h58;
   localparam logic [7:0] CMD_TON_DLY = 8'h60;
   localparam logic [7:0] CMD_RAMP_TIME = 8'h61;
   localparam logic [7:0] CMD_TMO_LIMIT = 8'h62;

   // ------------------------------------------------------------
   // Word layout and reset values
   // ------------------------------------------------------------
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 11;
   localparam int MAN_MSB = 10;
   localparam logic [4:0] UV_EXP_RST = 5'h1E;
   localparam logic [4:0] DLY_EXP_RST = 5'h1F;
   localparam logic [4:0] RISE_EXP_RST = 5'h1E;
   localparam logic [4:0] TMO_EXP_RST = 5'h1F;
   localparam logic [10:0] UV_MAN_RST = 11'h00A;

   // ------------------------------------------------------------
   // Fixed-point units: volts in 1/16 V, time in 1/4 ms
   // ------------------------------------------------------------
   localparam int V_FRAC = 4;
   localparam int T_FRAC = 2;
   localparam logic [19:0] UV_MIN = 20'h0_0050;
   localparam logic [19:0] UV_MAX = 20'h0_0160;
   localparam logic [19:0] DLY_MAX = 20'h0_01FE;
   localparam logic [19:0] RISE_MAX = 20'h0_007F;
   localparam logic [9:0] RISE_FLOOR = 10'h002;
   localparam logic [19:0] TMO_MAX = 20'h0_01FC;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ = 10000;
   localparam int TICK_US = 250;
   localparam int INIT_US = 100;
   localparam int TICK_CYC = (TICK_US * CLK_KHZ) / 1000;
   localparam int INIT_CYC = (INIT_US * CLK_KHZ + 999) / 1000;
   localparam logic [11:0] RAMP_FULL = 12'h400;

   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int SB_NONE_ABOVE = 0;
   localparam int SB_CML = 1;
   localparam int SW_VOUT = 15;
   localparam int SW_INPUT = 13;
   localparam int SI_UV_WARN = 5;
   localparam int SV_STARTUP_TMO = 2;
   localparam int SC_BAD_CMD = 7;
   localparam int SC_BAD_DATA = 6;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_INIT  = 3'b001,
      ST_DELAY = 3'b010,
      ST_RAMP  = 3'b011,
      ST_ON    = 3'b100
   } stt_state_e;

   // Linear word to unsigned fixed point; negatives saturate high
   function automatic logic [19:0] stt_lin_fix(input logic [15:0] w,
                                                input int frac);
      logic signed [4:0]  e;
      logic signed [10:0] m;
      logic signed [31:0] v;
      int                 sh;
      e  = w[EXP_MSB:EXP_LSB];
      m  = w[MAN_MSB:0];
      sh = int'(e) + frac;
      if (sh >= 0)
         v = 32'(m) <<< sh;
      else
         v = 32'(m) >>> (-sh);
      if (v < 0 || v > 32'h000F_FFFF)
         return 20'hF_FFFF;
      return v[19:0];
   endfunction

endpackage

// ---- src/stt_mon_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface stt_mon_if #(parameter int PHASES = 1);
   logic [15:0]          threshold;
   logic [PHASES*16-1:0] rail;
   logic [PHASES-1:0]    uvw;
   modport ctl (output threshold, output rail, input uvw);
   modport mon (input threshold, input rail, output uvw);
endinterface
`default_nettype wire

// ---- src/stt_uv_mon.sv ----
`timescale 1ns/10ps
`default_nettype none
module stt_uv_mon #(parameter int PHASES = 1)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Threshold, samples, flags
   stt_mon_if.mon   mon
);
   import stt_pkg::*;

   // ------------------------------------------------------------
   // One comparator per phase
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_phase
         wire logic below;
         assign below = mon.rail[g*16 +: 16] < mon.threshold;
         always_ff @(posedge mclk)
         begin
            if (rst)
               mon.uvw[g] <= 1'b0;
            else
               mon.uvw[g] <= below;
         end
      end
   endgenerate
endmodule // stt_uv_mon
`default_nettype wire

// ---- src/stt_tick.sv ----
`timescale 1ns/10ps
`default_nettype none
module stt_tick
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Control and tick
   input  wire logic restart,
   output logic      tick
);
   import stt_pkg::*;

   localparam logic [11:0] LAST = 12'(TICK_CYC - 1);
   logic [11:0] cnt_q;
   wire logic   wrap;
   assign wrap = (cnt_q == LAST);
   assign tick = wrap & ~restart;

   // Quarter-millisecond base, zeroed on each start
   always_ff @(posedge mclk)
   begin
      if (rst || restart || wrap)
         cnt_q <= 12'h000;
      else
         cnt_q <= cnt_q + 12'h001;
   end
endmodule // stt_tick
`default_nettype wire

// ---- tb/stt_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module stt_monitor #(parameter int PHASES = 1)
(
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // Command port
   input wire logic              cmd_valid,
   input wire logic              cmd_ack,
   input wire logic              cmd_err,
   // Sequencing
   input wire logic              start_pin,
   input wire logic              output_enable,
   input wire logic              ramp_active,
   input wire logic              uv_compare_enable,
   // Status
   input wire logic [PHASES-1:0] input_uv_warning_flag,
   input wire logic [7:0]        status_byte,
   input wire logic [15:0]       status_word,
   input wire logic [7:0]        status_input,
   input wire logic [7:0]        status_vout,
   input wire logic [7:0]        status_cml,
   input wire logic              notify_host
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_ack_after_cmd: assert property (cmd_valid |=> cmd_ack)
      else $error("no ack after command");
   a_err_with_ack: assert property (cmd_err |-> cmd_ack)
      else $error("error without ack");
   a_bad_data_flag: assert property ($rose(status_cml[6])
      |-> ##[0:1] (status_byte[1] && notify_host))
      else $error("invalid data not reported");
   a_uv_warn_status: assert property (input_uv_warning_flag[0]
      |-> ##[0:2] (status_input[5] && status_word[13] && status_byte[0]
                   && notify_host))
      else $error("uv warning status missing");
   a_tmo_status: assert property ($rose(status_vout[2])
      |-> ##[0:1] (status_word[15] && status_byte[0] && notify_host))
      else $error("timeout status missing");
   a_init_wait: assert property ($rose(start_pin)
      |-> ##1 (!output_enable)[*8])
      else $error("output enabled without wait");
   a_cmp_after_ramp: assert property (ramp_active |-> !uv_compare_enable)
      else $error("uv compare during ramp");
   a_ramp_min_len: assert property ($rose(ramp_active) |-> ramp_active[*8])
      else $error("ramp too short");
endmodule // stt_monitor
`default_nettype wire

// ---- tb/stt_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module stt_host
(
   // Clock
   input wire logic        mclk,
   // Word command port
   output logic            cmd_valid,
   output logic            cmd_write,
   output logic [7:0]      cmd_code,
   output logic [15:0]     cmd_wdata,
   input wire logic        cmd_ack,
   input wire logic        cmd_err,
   input wire logic [15:0] cmd_rdata
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One word read or write; ok low when no answer came
   task automatic xfer(input logic w, input logic [7:0] c,
                       input logic [15:0] d, output logic ok,
                       output logic err, output logic [15:0] rd);
      int n;
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code  = c;
      cmd_wdata = d;
      n  = 0;
      ok = 1'b0;
      while (!ok && n < 4)
      begin
         @(negedge mclk);
         cmd_valid = 1'b0;
         ok = (cmd_ack === 1'b1);
         n++;
      end
      err = cmd_err;
      rd  = cmd_rdata;
      @(negedge mclk);
      cmd_code  = ~c;
      cmd_wdata = ~d;
   endtask
endmodule // stt_host
`default_nettype wire

// ---- tb/stt_seq_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module stt_seq_tb;
   import stt_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic             mclk = 1'b0;
   logic             rst = 1'b1;
   logic             restore = 1'b0;
   logic             clear_faults = 1'b0;
   logic             start_pin = 1'b0;
   logic             vout_sample_valid = 1'b0;
   logic [15:0]      power_input_rail = 16'h0170;
   logic [15:0]      vout_sample = 16'h0000;
   logic [15:0]      vout_command = 16'h0010;
   wire logic        cmd_valid, cmd_write, cmd_ack, cmd_err, notify_host;
   wire logic        output_enable, ramp_active, uv_compare_enable;
   wire logic [0:0]  input_uv_warning_flag;
   wire logic [7:0]  cmd_code, status_byte, status_input, status_vout;
   wire logic [7:0]  status_cml;
   wire logic [15:0] cmd_wdata, cmd_rdata, ref_level, status_word;
   int               failures = 0;
   int               checked = 0;
   logic             ok, err;
   logic [15:0]      rd;
   logic [15:0]      shadow [logic [7:0]];
   logic [7:0]       wc [12] = '{8'h58, 8'h58, 8'h58, 8'h58, 8'h58, 8'h60,
                                 8'h61, 8'h61, 8'h61, 8'h62, 8'h62, 8'h59};
   logic [15:0]      wd [12] = '{16'hF010, 16'hF82C, 16'hF809, 16'hF82E,
                                 16'hF818, 16'hF003, 16'hF080, 16'hF07F,
                                 16'hF000, 16'hF001, 16'hF802, 16'h1234};
   logic [11:0]      we = 12'hA6D;

   initial
   begin
      forever #50 mclk = ~mclk;
   end

   stt_seq dut (.mclk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
      .cmd_ack, .cmd_err, .cmd_rdata, .restore, .clear_faults, .start_pin,
      .power_input_rail, .vout_sample, .vout_sample_valid, .vout_command,
      .output_enable, .ramp_active, .ref_level, .uv_compare_enable,
      .input_uv_warning_flag, .status_byte, .status_word, .status_input,
      .status_vout, .status_cml, .notify_host);
   stt_host host (.mclk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
      .cmd_ack, .cmd_err, .cmd_rdata);

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      host.xfer(w, c, d, ok, err, rd);
      check("ack", 16'(ok), 16'h0001);
      if (!ok)
         final_report;
   endtask

   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      @(negedge mclk);
   endtask

   // Start with delay d and init i cycles; flt is the expected timeout
   task automatic power_up(input int d, input int i, input logic [15:0] s,
                           input logic flt);
      int n;
      vout_sample = s;
      pulse(vout_sample_valid);
      pulse(clear_faults);
      start_pin = 1'b1;
      n = 0;
      while (output_enable !== 1'b1 && n < 20000)
      begin
         @(negedge mclk);
         n++;
      end
      check("on_delay", 16'(n >= d && n >= i && n <= d + i + TICK_CYC + 6),
            16'h0001);
      n = 0;
      while (ramp_active === 1'b1 && n < 20000)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= 20000)
         final_report;
      check("ramp", 16'(n >= 2 * TICK_CYC - 3 && n <= 2 * TICK_CYC + 3),
            16'h0001);
      check("uv_cmp", 16'(uv_compare_enable), 16'h0001);
      repeat (2 * TICK_CYC + 10) @(negedge mclk);
      check("ref", ref_level, vout_command);
      check("tmo", 16'(status_vout[2]), 16'(flt));
      start_pin = 1'b0;
      repeat (10) @(negedge mclk);
      check("off", 16'(output_enable), 16'h0000);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      shadow[8'h58] = 16'hF00A;
      shadow[8'h59] = 16'h0000;
      shadow[8'h60] = 16'hF800;
      shadow[8'h61] = 16'hF00C;
      shadow[8'h62] = 16'hF800;
      foreach (shadow[c])
      begin
         xfer(1'b0, c, 16'h0000);
         check("reset_value", rd, shadow[c]);
      end
      for (int i = 0; i < 12; i++)
      begin
         xfer(1'b1, wc[i], wd[i]);
         check("write_err", 16'(err), 16'(we[i]));
         if (!we[i])
            shadow[wc[i]] = wd[i];
         xfer(1'b0, wc[i], 16'h0000);
         check("readback", rd, shadow[wc[i]]);
      end
      check("cml", {status_cml, 7'h00, notify_host}, 16'hC001);
      pulse(clear_faults);
      power_input_rail = 16'h00C0;
      repeat (3) @(negedge mclk);
      check("uv_edge", 16'(input_uv_warning_flag), 16'h0000);
      power_input_rail = 16'h00BF;
      repeat (3) @(negedge mclk);
      check("uv_low", 16'(input_uv_warning_flag), 16'h0001);
      check("uv_stat", {status_input, status_word[13], status_byte[0],
            notify_host, 5'h00}, 16'h20E0);
      power_input_rail = 16'h0170;
      power_up(0, INIT_CYC, 16'h0000, 1'b1);
      xfer(1'b1, 8'h60, 16'hE805);
      pulse(restore);
      xfer(1'b0, 8'h60, 16'h0000);
      check("restore", rd, 16'hF801);
      power_up(2 * TICK_CYC, 0, 16'h000E, 1'b0);
      xfer(1'b1, 8'h62, 16'hF800);
      power_up(2 * TICK_CYC, 0, 16'h0000, 1'b0);
      final_report;
   end
endmodule // stt_seq_tb

bind stt_seq stt_monitor #(.PHASES(PHASES)) u_mon (.mclk, .rst, .cmd_valid,
   .cmd_ack, .cmd_err, .start_pin, .output_enable, .ramp_active,
   .uv_compare_enable, .input_uv_warning_flag, .status_byte, .status_word,
   .status_input, .status_vout, .status_cml, .notify_host);
`default_nettype wire
